// ### logic/eop_ctrl.sv
// EEPROM options, protection and program control with APB access
`timescale 1ns/1ps
`default_nettype none
module eop_ctrl
  import eop_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System modes
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        bootstrap_entry,
  input  wire logic        test_mode_req,
  input  wire logic        bus_ctrl_sleep_flag,
  input  wire logic        converter_rc_clock_select,
  // Status and pump
  output logic             test_mode_grant,
  output logic             pump_on,
  output logic             pump_clk_out,
  output logic             upper_area_protect,
  output logic             secure_lock,
  output logic             wired_or_irq_enable,
  output logic             ext_clock_out_option
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    eop_state_t  st;
    logic        irq_en;
    logic        clk_opt;
    logic        era;
    logic        lat;
    logic        pgm;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [7:0]  wipe;
    logic        load_pend;
    logic        prot;
    logic        secure;
    logic        grant;
    logic        pump;
    logic        pclk_out;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } eop_ctl_t;

  eop_ctl_t   s_q, s_d;
  logic [7:0] mem [ARR_DEPTH];
  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic       tmr_start;
  logic       tmr_abort;
  logic       tmr_done;
  logic       pump_clk_w;
  logic [9:0] idx;
  logic       acc;
  logic [7:0] rd_byte;
  logic [7:0] burn_val;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic in_array(input logic [9:0] i);
    in_array = (i >= OPT_IDX) && (i <= ARR_LAST);
  endfunction

  function automatic logic is_locked(input logic [7:0] a, input logic prot);
    is_locked = !prot && (a >= FREE_BYTES);
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  eop_op_timer u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .abort   (tmr_abort),
    .done    (tmr_done)
  );

  eop_pump_clk u_pck (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (s_q.pump),
    .rc_sel   (converter_rc_clock_select),
    .pump_clk (pump_clk_w)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d       = s_q;
    idx       = paddr[11:2];
    acc       = psel && penable && s_q.ready;
    mem_we    = 1'b0;
    mem_wa    = s_q.addr;
    mem_wd    = s_q.data;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    rd_byte   = mem[idx[7:0]];
    burn_val  = s_q.era ? ERASED : (mem[s_q.addr] & s_q.data);

    // One-wait-state answer: pready comes the cycle after the first access cycle
    s_d.ready = psel && penable && !s_q.ready;
    if (s_d.ready) begin
      s_d.slverr = 1'b0;
      s_d.rdata  = '0;
      if (idx == CTRL_IDX) begin
        s_d.rdata[B_IRQ_EN] = s_q.irq_en;
        s_d.rdata[B_SLEEP] = bus_ctrl_sleep_flag;
        s_d.rdata[B_CLK_OPT] = s_q.clk_opt;
        s_d.rdata[B_ERA]   = s_q.era;
        s_d.rdata[B_LAT]   = s_q.lat;
        s_d.rdata[B_PGM]   = s_q.pgm;
      end else if (in_array(idx)) begin
        s_d.rdata[7:0] = s_q.lat ? BLOCKED_RD : rd_byte;
      end else begin
        s_d.slverr = 1'b1;
      end
    end

    // Catch options byte after reset release
    if (s_q.load_pend) begin
      s_d.load_pend = 1'b0;
      s_d.prot      = mem[OPT_IDX[7:0]][B_PROTECT];
      s_d.secure    = mem[OPT_IDX[7:0]][B_SECURE];
    end

    // Control register writes
    if (acc && pwrite && idx == CTRL_IDX && s_q.st != ST_WIPE) begin
      s_d.irq_en  = pwdata[B_IRQ_EN];
      s_d.clk_opt = pwdata[B_CLK_OPT];
      s_d.lat  = pwdata[B_LAT];
      if (!pwdata[B_LAT]) begin
        s_d.era = 1'b0;
        s_d.pgm = 1'b0;
      end else begin
        if (s_q.st == ST_IDLE || s_q.st == ST_ARMED) begin
          s_d.era = pwdata[B_ERA];
        end
        if (pwdata[B_PGM] && s_q.st == ST_LOADED) begin
          s_d.pgm = 1'b1;
        end
      end
    end

    // Sequencer; wait_mode has no effect here
    case (s_q.st)
      ST_IDLE: begin
        if (s_d.lat) begin
          s_d.st = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!s_d.lat) begin
          s_d.st = ST_IDLE;
        end else if (acc && pwrite && in_array(idx)) begin
          s_d.addr = idx[7:0];
          s_d.data = pwdata[7:0];
          s_d.st   = ST_LOADED;
        end
      end
      ST_LOADED: begin
        if (!s_d.lat) begin
          s_d.st = ST_IDLE;
        end else if (s_d.pgm && !s_q.pgm) begin
          // Only the write that sets pgm starts a burn; no re-burn after done
          tmr_start = 1'b1;
          s_d.pump  = 1'b1;
          s_d.st    = ST_BURN;
        end
      end
      ST_BURN: begin
        if (!s_d.lat) begin
          tmr_abort = 1'b1;
          s_d.pump  = 1'b0;
          s_d.st    = ST_IDLE;
        end else if (tmr_done) begin
          // Locked target keeps its contents, no flag raised
          if (!is_locked(s_q.addr, s_q.prot)) begin
            mem_we = 1'b1;
          end
          s_d.pump = 1'b0;
          s_d.st   = ST_LOADED;
        end
      end
      ST_WIPE: begin
        mem_we   = 1'b1;
        mem_wa   = s_q.wipe;
        mem_wd   = ERASED;
        s_d.wipe = s_q.wipe + 1'b1;
        if (s_q.wipe == 8'(ARR_DEPTH - 1)) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    if (mem_we && s_q.st == ST_BURN) begin
      mem_wd = burn_val;
    end

    // Burned-back byte in a loaded slot stays loaded until latch clears
    if (s_q.st == ST_BURN && tmr_done) begin
      s_d.pgm = 1'b1;
    end

    // STOP forces read mode and kills the pump
    if (stop_mode) begin
      s_d.lat  = 1'b0;
      s_d.era  = 1'b0;
      s_d.pgm  = 1'b0;
      s_d.pump = 1'b0;
      tmr_abort = s_q.st == ST_BURN;
      if (s_q.st != ST_WIPE) begin
        s_d.st = ST_IDLE;
      end
    end

    // Bootstrap entry wipes the whole array
    if (bootstrap_entry && s_q.st != ST_WIPE) begin
      s_d.st   = ST_WIPE;
      s_d.wipe = '0;
      s_d.lat  = 1'b0;
      s_d.era  = 1'b0;
      s_d.pgm  = 1'b0;
      s_d.pump = 1'b0;
      tmr_abort = 1'b1;
    end

    // Latched copies only; stored changes wait for reset
    s_d.grant    = test_mode_req && s_q.secure && !s_q.load_pend;
    s_d.pclk_out = pump_clk_w;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.st        <= ST_IDLE;
      s_q.load_pend <= 1'b1;
      s_q.irq_en    <= CTRL_RESET[B_IRQ_EN];
      s_q.clk_opt   <= CTRL_RESET[B_CLK_OPT];
    end else begin
      s_q <= s_d;
    end
  end

  // Nonvolatile array, untouched by reset
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata               = s_q.rdata;
  assign pready               = s_q.ready;
  assign pslverr              = s_q.slverr;
  assign test_mode_grant      = s_q.grant;
  assign pump_on              = s_q.pump;
  assign pump_clk_out         = s_q.pclk_out;
  assign upper_area_protect   = s_q.prot;
  assign secure_lock          = s_q.secure;
  assign wired_or_irq_enable  = s_q.irq_en;
  assign ext_clock_out_option = s_q.clk_opt;
endmodule
`default_nettype wire

// ### logic/eop_pkg.sv
// Constants for the EEPROM option and protection controller
//
// Overview of operation
// - Options byte is copied into working latches after each reset.
// - Lowest 32 bytes are never protected; upper 224 bytes follow the protect latch.
// - Protect latch low makes upper-region erase or program fail silently.
// - Protect latch high allows every operation on all 256 bytes.
// - New stored protect value acts only after the next reset.
// - Protect bit can only be cleared while latch enable is set.
// - Security latch low refuses every test-mode entry.
// - Bootstrap entry erases the whole array, returning security bit to one.
// - New stored security value acts only after the next reset.
// - STOP forces read mode and switches the charge pump off.
// - WAIT leaves the array and pump untouched; operations complete normally.
// - Options byte is nonvolatile, protect at bit 1, security at bit 0.
// - Latch enable low holds erase select and pump enable at zero; pgm stays set if a write clears the latch in the cycle a burn ends.
// - Erased byte reads all ones, programmed bits read zero.
package eop_pkg;
  // ----------------------------------------
  // Register indices (byte address is 4x)
  // ----------------------------------------
  localparam logic [9:0] CTRL_IDX    = 10'h007;
  localparam logic [9:0] OPT_IDX     = 10'h100;
  localparam logic [9:0] ARR_LAST    = 10'h1ff;
  localparam logic [7:0] FREE_BYTES  = 8'h20;
  localparam int         ARR_DEPTH   = 256;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int         B_IRQ_EN    = 7;
  localparam int         B_SLEEP     = 6;
  localparam int         B_CLK_OPT   = 3;
  localparam int         B_ERA       = 2;
  localparam int         B_LAT       = 1;
  localparam int         B_PGM       = 0;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  // ----------------------------------------
  // Options byte fields and array values
  // ----------------------------------------
  localparam int         B_PROTECT   = 1;
  localparam int         B_SECURE    = 0;
  localparam logic [7:0] ERASED      = 8'hff;
  localparam logic [7:0] BLOCKED_RD  = 8'hff;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CLK_MHZ      = 25;
  localparam int         PROG_TIME_US = 10;
  localparam int         PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam int         PUMP_DIV     = 4;
  localparam int         RC_DIV       = 16;
  localparam int         TMR_W        = 16;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_ARMED  = 5'b00010,
    ST_LOADED = 5'b00100,
    ST_BURN   = 5'b01000,
    ST_WIPE   = 5'b10000
  } eop_state_t;
endpackage

// ### logic/eop_op_timer.sv
// Countdown timer for one erase or program burn
`timescale 1ns/1ps
`default_nettype none
module eop_op_timer
  import eop_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             run;
    logic             done;
  } eop_tmr_t;
  eop_tmr_t s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (abort) begin
      s_d.run = 1'b0;
    end else if (start) begin
      s_d.run = 1'b1;
      s_d.cnt = TMR_W'(PROG_CYCLES - 1);
    end else if (s_q.run) begin
      if (s_q.cnt == '0) begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule
`default_nettype wire

// ### logic/eop_pump_clk.sv
// Charge pump clock divider from CPU rate or RC rate
`timescale 1ns/1ps
`default_nettype none
module eop_pump_clk
  import eop_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic run,
  input  wire logic rc_sel,
  output logic      pump_clk
);
  typedef struct packed {
    logic [7:0] div;
    logic       clk;
  } eop_pck_t;
  eop_pck_t s_q, s_d;
  logic [7:0] limit;

  always_comb begin
    limit = rc_sel ? 8'(RC_DIV - 1) : 8'(PUMP_DIV - 1);
    s_d   = s_q;
    if (!run) begin
      s_d = '0;
    end else if (s_q.div >= limit) begin
      s_d.div = '0;
      s_d.clk = ~s_q.clk;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pump_clk = s_q.clk;
endmodule
`default_nettype wire

// ### tb/eop_ctrl_monitor.sv
// Concurrent checks on the EEPROM option controller ports
`timescale 1ns/1ps
`default_nettype none
module eop_ctrl_monitor
  import eop_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Modes and status
  input wire logic        stop_mode,
  input wire logic        test_mode_req,
  input wire logic        test_mode_grant,
  input wire logic        pump_on,
  input wire logic        pump_clk_out,
  input wire logic        upper_area_protect,
  input wire logic        secure_lock
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [1:0] age_q;
  logic [8:0] burn_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q  <= 2'h0;
      burn_q <= 9'h000;
    end else begin
      age_q  <= (age_q == 2'h2) ? age_q : age_q + 2'h1;
      burn_q <= !pump_on ? 9'h000 : (burn_q == 9'h1ff) ? burn_q : burn_q + 9'h001;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_GRANT_CAUSE: assert property (test_mode_grant |-> $past(test_mode_req && secure_lock))
    else $error("test mode granted while secured");
  AST_GRANT_GIVEN: assert property (test_mode_req && secure_lock |=> test_mode_grant)
    else $error("test mode refused while unsecured");
  AST_LATCH_HOLD: assert property (age_q == 2'h2 |-> $stable(upper_area_protect) && $stable(secure_lock))
    else $error("option latches changed without reset");
  AST_STOP_PUMP: assert property (stop_mode |=> !pump_on)
    else $error("pump still on in stop");
  AST_PUMP_QUIET: assert property (!pump_on && !$past(pump_on) && !$past(pump_on, 2)
    && !$past(pump_on, 3) |-> $stable(pump_clk_out))
    else $error("pump clock runs with pump off");
  AST_BURN_LEN: assert property (pump_on |-> burn_q <= 9'(PROG_CYCLES))
    else $error("burn longer than its time");
  AST_ARRAY_NO_ERR: assert property (pready && paddr[11:10] == 2'h1 |-> !pslverr)
    else $error("array access flagged an error");
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the EEPROM option controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import eop_pkg::*;
;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} eop_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        stop_mode = 1'b0, wait_mode = 1'b0, bootstrap_entry = 1'b0, test_mode_req = 1'b0;
  logic        bus_ctrl_sleep_flag = 1'b0, converter_rc_clock_select = 1'b0, er;
  logic        pready, pslverr, test_mode_grant, pump_on, pump_clk_out;
  logic        upper_area_protect, secure_lock, wired_or_irq_enable, ext_clock_out_option;
  int          mismatches = 0, comparisons = 0;
  eop_row_t    rows [11] = '{
    '{1'b0, 12'h01c, 32'h0, 32'h40, 1'b0}, '{1'b1, 12'h01c, 32'h88, 32'h0, 1'b0},
    '{1'b0, 12'h01c, 32'h0, 32'hc8, 1'b0}, '{1'b1, 12'h01c, 32'h8d, 32'h0, 1'b0},
    '{1'b0, 12'h01c, 32'h0, 32'hc8, 1'b0}, '{1'b1, 12'h01c, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h400, 32'h0, 32'hff, 1'b0}, '{1'b0, 12'h7fc, 32'h0, 32'hff, 1'b0},
    '{1'b0, 12'h800, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h000, 32'h1, 32'h0, 1'b1},
    '{1'b0, 12'h018, 32'h0, 32'h0, 1'b1}};
  always #20 pclk = ~pclk;
  eop_ctrl u_eop_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .stop_mode, .wait_mode, .bootstrap_entry, .test_mode_req,
    .bus_ctrl_sleep_flag, .converter_rc_clock_select, .test_mode_grant, .pump_on, .pump_clk_out,
    .upper_area_protect, .secure_lock, .wired_or_irq_enable, .ext_clock_out_option);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    summarize();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic prog(input logic [7:0] i, input logic [7:0] d, input logic era, input logic tm);
    int   n;
    int   t;
    logic p;
    n = 0;
    t = 0;
    p = pump_clk_out;
    apb(1'b1, 12'h01c, {29'h0, era, 2'h2});
    apb(1'b1, 12'h400 + {2'h0, i, 2'h0}, {24'h0, d});
    apb(1'b1, 12'h01c, {29'h0, era, 2'h3});
    do begin
      @(negedge pclk);
      n++;
      if (pump_clk_out !== p) t++;
      p = pump_clk_out;
    end while (pump_on !== 1'b0 && n < 400);
    if (n >= 400) hang();
    if (tm) chk({31'h0, n >= 245 && n <= 255}, 32'h1);
    chk({31'h0, t != 0}, 32'h1);
    apb(1'b1, 12'h01c, 32'h0);
  endtask
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
  endtask
  task automatic boot();
    @(posedge pclk);
    bootstrap_entry <= 1'b1;
    @(posedge pclk);
    bootstrap_entry <= 1'b0;
    repeat (300) @(posedge pclk);
    rst();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    boot();
    @(posedge pclk);
    bus_ctrl_sleep_flag <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].a, rows[k].d);
      if (!rows[k].w) chk(rd, rows[k].r);
      chk({31'h0, er}, {31'h0, rows[k].e});
    end
    bus_ctrl_sleep_flag <= 1'b0;
    apb(1'b1, 12'h01c, 32'h88);
    @(negedge pclk);
    chk({30'h0, wired_or_irq_enable, ext_clock_out_option}, 32'h3);
    wait_mode <= 1'b1;
    converter_rc_clock_select <= 1'b1;
    prog(8'h1f, 8'h5a, 1'b0, 1'b1);
    rdc(12'h47c, 32'h5a);
    {wait_mode, converter_rc_clock_select} <= 2'h0;
    prog(8'h20, 8'h00, 1'b0, 1'b0);
    rdc(12'h480, 32'h00);
    prog(8'h20, 8'h00, 1'b1, 1'b0);
    rdc(12'h480, 32'hff);
    test_mode_req <= 1'b1;
    prog(8'h00, 8'hfc, 1'b0, 1'b0);
    rdc(12'h400, 32'hfc);
    chk({30'h0, upper_area_protect, secure_lock}, 32'h3);
    chk({31'h0, test_mode_grant}, 32'h1);
    rst();
    chk({29'h0, upper_area_protect, secure_lock, test_mode_grant}, 32'h0);
    rdc(12'h400, 32'hfc);
    prog(8'h20, 8'h00, 1'b0, 1'b0);
    rdc(12'h480, 32'hff);
    chk({31'h0, er}, 32'h0);
    prog(8'h1f, 8'h00, 1'b0, 1'b0);
    rdc(12'h47c, 32'h00);
    apb(1'b1, 12'h01c, 32'h2);
    apb(1'b1, 12'h478, 32'h0);
    apb(1'b1, 12'h01c, 32'h3);
    repeat (5) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (2) @(negedge pclk);
    chk({31'h0, pump_on}, 32'h0);
    rdc(12'h01c, 32'h00);
    rdc(12'h478, 32'hff);
    stop_mode <= 1'b0;
    boot();
    chk({30'h0, upper_area_protect, secure_lock}, 32'h3);
    rdc(12'h47c, 32'hff);
    apb(1'b1, 12'h400, 32'h0);
    rdc(12'h400, 32'hff);
    summarize();
  end
endmodule
bind eop_ctrl eop_ctrl_monitor u_eop_ctrl_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .stop_mode, .test_mode_req, .test_mode_grant, .pump_on,
  .pump_clk_out, .upper_area_protect, .secure_lock);
`default_nettype wire
